// file: sss_pkg.sv
// Package for the simple command sequencer: register map, opcodes, fields, timing.
// Assumes a 50 MHz core clock and an Avalon-MM slave with 32-bit data.
package sss_pkg;

  // Register byte offsets
  localparam logic [5:0] REG_CMD_OFS    = 6'h00; // Command: opcode[7:0], single-byte bit [8]
  localparam logic [5:0] REG_CTRL_OFS   = 6'h04; // Control: dma mode, halt bits
  localparam logic [5:0] REG_IDS_OFS    = 6'h08; // Own id [2:0], target id [10:8]
  localparam logic [5:0] REG_TMO_OFS    = 6'h0C; // Timeout period, units of 8 us
  localparam logic [5:0] REG_SYNC_OFS   = 6'h10; // Sync transfer: period [3:0], offset [7:4]
  localparam logic [5:0] REG_COUNT_OFS  = 6'h14; // Transfer count [11:0]
  localparam logic [5:0] REG_DATA_OFS   = 6'h18; // Data register [7:0]
  localparam logic [5:0] REG_AUX_OFS    = 6'h1C; // Aux flags (read only)
  localparam logic [5:0] REG_STAT_OFS   = 6'h20; // Status code, read clears irq

  // Opcodes
  localparam logic [7:0] OP_ABORT      = 8'h01;
  localparam logic [7:0] OP_DISCONNECT = 8'h04;
  localparam logic [7:0] OP_RESELECT   = 8'h05;
  localparam logic [7:0] OP_SEL_ATN    = 8'h06;
  localparam logic [7:0] OP_SEL_NOATN  = 8'h07;
  localparam logic [7:0] OP_RECV_BASE  = 8'h10;
  localparam logic [7:0] OP_SEND_BASE  = 8'h14;
  localparam logic [7:0] OP_XFER_LAST  = 8'h17;

  // Status codes
  localparam logic [7:0] ST_SUCCESS  = 8'h16;
  localparam logic [7:0] ST_PAUSED   = 8'h20;
  localparam logic [7:0] ST_TERMINAT = 8'h42;
  localparam logic [7:0] ST_SVC_REQ  = 8'h81;

  // Field positions
  localparam int SBT_BIT   = 8;
  localparam int DMA_LSB   = 0;
  localparam int HSP_BIT   = 4;
  localparam int HHP_BIT   = 5;
  localparam int HA_BIT    = 6;

  // Timing
  localparam int CLK_MHZ       = 50;
  localparam int ABORT_US      = 200;
  localparam int ABORT_CYC     = ABORT_US * CLK_MHZ;   // Least time, exact
  localparam int TMO_UNIT_US   = 8;
  localparam int TMO_UNIT_CYC  = TMO_UNIT_US * CLK_MHZ;
  localparam int ARB_US        = 3;
  localparam int ARB_CYC       = ARB_US * CLK_MHZ;     // Arbitration delay, least

  // Connection states
  typedef enum logic [1:0] {
    CONN_NONE, CONN_INIT, CONN_TARG
  } sss_conn_t;

  // Parallel bus pins (driven side): one bit each, except the eight data lines
  typedef struct packed {
    logic       sel;
    logic       atn;
    logic       bsy;
    logic       io;
    logic       cd;
    logic       msg;
    logic       req;
    logic [7:0] data;
    logic       dbp;
  } sss_bus_t;

endpackage : sss_pkg

// file: sss_sequencer.sv
// Simple command sequencer: selection, reselection, target receive and send.
// Assumes an Avalon-MM master on core_clk_i and bus pins from outside the clock domain.
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps

// Notes on behaviour
// - Select-with-attention accepted only when disconnected
// - Selected during arbitration gives service-required interrupt
// - Assert SEL, ATN, ids, then drop BSY
// - Timeout runs abort sequence, then terminated
// - Target BSY ends selection as initiator, success
// - Abort before connection gives paused status, disconnected
// - Select-without-attention never drives ATN
// - Reselect drives I/O, ends connected target
// - Receive opcodes drive phase lines, target only
// - Send opcodes drive phase lines, target only
// - Single-byte or zero count: one byte
// - Counter decrements per byte, zero means success
// - Halting receive parity error terminates, count kept
// - Halting host parity error terminates send
// - Halting attention, abort, disconnect, reset end transfers
// - Receive ready flag: set on arrival, clear
// - Send ready flag: clear on write, set
// - Synchronous only for data with offset
// - Abort sequence drops ids, waits 200 us
module sss_sequencer
  import sss_pkg::*;
#(
  parameter int ABORT_CYCLES = ABORT_CYC,
  parameter int TMO_UNIT     = TMO_UNIT_CYC
) (
  // Clock, enable, reset
  input  wire logic        core_clk_i,
  input  wire logic        clk_en_i,
  input  wire logic        rst_b_i,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Host-side parity of written data byte
  input  wire logic        host_parity_i,
  // Bus inputs
  input  wire logic        bus_bsy_i,
  input  wire logic        bus_sel_i,
  input  wire logic        bus_atn_i,
  input  wire logic        bus_ack_i,
  input  wire logic        bus_lost_i,
  input  wire logic [7:0]  bus_data_i,
  input  wire logic        bus_dbp_i,
  // Bus outputs and enables
  output sss_bus_t         bus_o,
  output logic             bus_data_oe_o,
  output logic             sync_mode_o,
  output logic             irq_o
);

  typedef enum logic [3:0] {
    S_IDLE, S_ARB, S_SELECT, S_WAIT, S_ABSEQ, S_XREQ, S_XACK, S_DONE
  } sss_state_t;

  // Sequencer state and the command in progress
  sss_state_t  state_r;
  sss_conn_t   conn_r;
  logic [7:0]  op_r;
  logic        sbt_r;
  // Software-written configuration
  logic [6:0]  ctrl_r;
  logic [2:0]  own_id_r;
  logic [2:0]  tgt_id_r;
  logic [7:0]  tmo_r;
  logic [7:0]  sync_r;
  // Transfer counter, data register and its ready flag
  logic [11:0] count_r;
  logic [7:0]  data_r;
  logic        dpar_r;
  logic        dbr_r;
  // Completion status and interrupt
  logic [7:0]  status_r;
  logic        irq_r;
  // Arbitration and timeout timer, abort counter; perr_r also marks an abort
  logic [31:0] timer_r;
  logic [31:0] ab_cnt_r;
  logic        perr_r;

  // Two-flop synchronisers for bus inputs
  logic [13:0] sync1_r;
  logic [13:0] sync2_r;
  wire  [13:0] pins_w = {bus_dbp_i, bus_data_i, bus_lost_i, bus_ack_i, bus_atn_i,
                         bus_sel_i, bus_bsy_i};
  // Synchronised pin levels, two cycles behind the pins
  wire         s_bsy  = sync2_r[0];
  wire         s_sel  = sync2_r[1];
  wire         s_atn  = sync2_r[2];
  wire         s_ack  = sync2_r[3];
  wire         s_lost = sync2_r[4];
  wire  [7:0]  s_data = sync2_r[12:5];
  wire         s_dbp  = sync2_r[13];

  // Bus decode; one-cycle wait on reads so read data comes from flip-flops
  logic rd_pend_r;
  // Writes take effect at the edge they are seen; only reads wait
  wire  wr_en    = clk_en_i & avs_write_i;
  wire  rd_done  = clk_en_i & avs_read_i & rd_pend_r;
  wire  wr_cmd   = wr_en & (avs_address_i == REG_CMD_OFS);
  wire  wr_ctrl  = wr_en & (avs_address_i == REG_CTRL_OFS);
  wire  wr_ids   = wr_en & (avs_address_i == REG_IDS_OFS);
  wire  wr_tmo   = wr_en & (avs_address_i == REG_TMO_OFS);
  wire  wr_sync  = wr_en & (avs_address_i == REG_SYNC_OFS);
  wire  wr_count = wr_en & (avs_address_i == REG_COUNT_OFS);
  wire  wr_data  = wr_en & (avs_address_i == REG_DATA_OFS);
  wire  rd_data  = rd_done & (avs_address_i == REG_DATA_OFS);
  wire  rd_stat  = rd_done & (avs_address_i == REG_STAT_OFS);
  assign avs_waitrequest_o = avs_read_i & ~rd_pend_r;

  // Command decode
  wire  [7:0] new_op   = avs_writedata_i[7:0];
  wire        is_sel   = (new_op == OP_SEL_ATN) | (new_op == OP_SEL_NOATN) |
                         (new_op == OP_RESELECT);
  wire        is_xfer  = (new_op >= OP_RECV_BASE) & (new_op <= OP_XFER_LAST);
  wire        go_sel   = wr_cmd & is_sel & (conn_r == CONN_NONE) & (state_r == S_IDLE);
  wire        go_xfer  = wr_cmd & is_xfer & (conn_r == CONN_TARG) & (state_r == S_IDLE);
  wire        do_abort = wr_cmd & (new_op == OP_ABORT);
  wire        do_disc  = wr_cmd & (new_op == OP_DISCONNECT);
  wire        sending  = op_r[2];                    // Opcodes 14..17 send
  wire        in_sel   = (state_r == S_SELECT) | (state_r == S_WAIT) | (state_r == S_ABSEQ);
  wire        in_xfer  = (state_r == S_XREQ) | (state_r == S_XACK);
  wire        halt_atn = in_xfer & ctrl_r[HA_BIT] & s_atn;
  wire        rx_perr  = ~sending & ctrl_r[HSP_BIT] & ~(^{s_data, s_dbp});
  // A zero count behaves like the single-byte bit
  wire        last_b   = sbt_r | (count_r <= 12'h001);
  // A zero timeout register disables the timeout; target BSY or abort is then the only way out
  wire [31:0] tmo_cyc  = 32'(tmo_r) * 32'(TMO_UNIT);
  wire        tmo_hit  = (tmo_r != 8'h00) & (timer_r >= tmo_cyc);
  // Both directions want an empty flag: receive has room, send has a fresh byte
  wire        byte_rdy = ~dbr_r;
  // Bad host parity on the waiting byte; REQ is held back so the byte never leaves
  wire        tx_perr  = sending & ~dbr_r & (dpar_r == ^data_r) & ctrl_r[HHP_BIT];
  // Arbitration won: delay run out and the bus not lost to another device
  wire        arb_won  = (state_r == S_ARB) & (timer_r >= 32'(ARB_CYC)) & ~s_lost;
  // Aux flags word, as software polls it
  wire [7:0]  aux_w    = {irq_r, in_sel | in_xfer, perr_r, 1'b0, conn_r, 1'b0, dbr_r};

  // Synchroniser flops
  // Reset clears the chain so no false BSY or ACK edge follows reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sync1_r <= 14'h0000;
      sync2_r <= 14'h0000;
    end else if (clk_en_i) begin
      sync1_r <= pins_w;
      sync2_r <= sync1_r;
    end
  end

  // Software-written configuration
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ctrl_r <= 7'h00;
      own_id_r <= 3'h7;
      tgt_id_r <= 3'h0;
      tmo_r <= 8'h00;
      sync_r <= 8'h00;
      rd_pend_r <= 1'b0;
    end else if (clk_en_i) begin
      // Read wait state toggles, so back-to-back reads each wait once
      rd_pend_r <= avs_read_i & ~rd_pend_r;
      if (wr_ctrl) ctrl_r <= avs_writedata_i[6:0];
      if (wr_ids) begin
        own_id_r <= avs_writedata_i[2:0];
        tgt_id_r <= avs_writedata_i[10:8];
      end
      if (wr_tmo) tmo_r <= avs_writedata_i[7:0];
      if (wr_sync) sync_r <= avs_writedata_i[7:0];
    end
  end

  // Read data mux, registered
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (clk_en_i && avs_read_i) begin
      case (avs_address_i)
        REG_CMD_OFS:   avs_readdata_o <= {23'h0, sbt_r, op_r};
        REG_CTRL_OFS:  avs_readdata_o <= {25'h0, ctrl_r};
        REG_IDS_OFS:   avs_readdata_o <= {21'h0, tgt_id_r, 5'h0, own_id_r};
        REG_TMO_OFS:   avs_readdata_o <= {24'h0, tmo_r};
        REG_SYNC_OFS:  avs_readdata_o <= {24'h0, sync_r};
        REG_COUNT_OFS: avs_readdata_o <= {20'h0, count_r};
        REG_DATA_OFS:  avs_readdata_o <= {24'h0, data_r};
        REG_AUX_OFS:   avs_readdata_o <= {24'h0, aux_w};
        REG_STAT_OFS:  avs_readdata_o <= {24'h0, status_r};
        default:       avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Sequencer: state, counters, data register and ready flag
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state_r <= S_IDLE;
      conn_r <= CONN_NONE;
      op_r <= 8'h00;
      sbt_r <= 1'b0;
      count_r <= 12'h000;
      data_r <= 8'h00;
      dpar_r <= 1'b0;
      dbr_r <= 1'b0;
      status_r <= 8'h00;
      irq_r <= 1'b0;
      timer_r <= 32'h0000_0000;
      ab_cnt_r <= 32'h0000_0000;
      perr_r <= 1'b0;
    end else if (clk_en_i) begin
      // Status read clears the interrupt; a new event the same cycle wins below
      if (rd_stat) irq_r <= 1'b0;
      if (wr_count) count_r <= avs_writedata_i[11:0];
      // Data register write by software; the host parity bit rides along
      if (wr_data) begin
        data_r <= avs_writedata_i[7:0];
        dpar_r <= host_parity_i;
        if (sending) dbr_r <= 1'b0;
      end
      if (rd_data && !sending) dbr_r <= 1'b0;
      // Accepted selection: arbitration timer starts from zero
      if (go_sel) begin
        op_r <= new_op;
        timer_r <= 32'h0000_0000;
        state_r <= S_ARB;
      end
      // Accepted transfer: flag starts empty for receive, ready for send
      if (go_xfer) begin
        op_r <= new_op;
        sbt_r <= avs_writedata_i[SBT_BIT];
        dbr_r <= new_op[2];
        perr_r <= 1'b0;
        state_r <= S_XREQ;
      end
      case (state_r)
        // Idle: commands start from the decode above
        S_IDLE: begin
        end
        // Arbitration: a selection by another device wins over our own
        S_ARB: begin
          timer_r <= timer_r + 32'h1;
          if (s_sel && !s_bsy) begin
            state_r <= S_DONE;
            status_r <= ST_SVC_REQ;
            irq_r <= 1'b1;
          end else if (do_abort) begin
            state_r <= S_DONE;
            status_r <= ST_PAUSED;
            irq_r <= 1'b1;
          end else if (arb_won) begin
            timer_r <= 32'h0000_0000;
            state_r <= S_SELECT;
          end
        end
        // One cycle with SEL, ATN and ids up while BSY is still held
        S_SELECT: begin
          timer_r <= 32'h0000_0000;
          state_r <= S_WAIT;
        end
        // BSY released; wait for the target, bounded by the timeout
        S_WAIT: begin
          timer_r <= timer_r + 32'h1;
          ab_cnt_r <= 32'h0000_0000;
          if (s_bsy) begin
            conn_r <= (op_r == OP_RESELECT) ? CONN_TARG : CONN_INIT;
            status_r <= ST_SUCCESS;
            irq_r <= 1'b1;
            state_r <= S_DONE;
          end else if (tmo_hit || do_abort) begin
            perr_r <= do_abort;
            state_r <= S_ABSEQ;
          end
        end
        // Ids off, SEL kept; a late BSY still counts as success
        S_ABSEQ: begin
          ab_cnt_r <= ab_cnt_r + 32'h1;
          if (s_bsy) begin
            conn_r <= (op_r == OP_RESELECT) ? CONN_TARG : CONN_INIT;
            status_r <= ST_SUCCESS;
            irq_r <= 1'b1;
            state_r <= S_DONE;
          end else if (ab_cnt_r >= 32'(ABORT_CYCLES)) begin
            status_r <= perr_r ? ST_PAUSED : ST_TERMINAT;
            perr_r <= 1'b0;
            irq_r <= 1'b1;
            state_r <= S_DONE;
          end
        end
        // Transfer: REQ while the flag is clear, byte on ACK, count on ACK drop
        S_XREQ, S_XACK: begin
          if (do_disc) begin
            conn_r <= CONN_NONE;
            state_r <= S_IDLE;
          end else if (do_abort || halt_atn) begin
            status_r <= ST_PAUSED;
            irq_r <= 1'b1;
            state_r <= S_DONE;
          end else if (state_r == S_XREQ) begin
            if (tx_perr) begin
              status_r <= ST_TERMINAT;
              irq_r <= 1'b1;
              state_r <= S_DONE;
            end else if (s_ack && byte_rdy) begin
              if (!sending && rx_perr) begin
                perr_r <= 1'b1;
                status_r <= ST_TERMINAT;
                irq_r <= 1'b1;
                state_r <= S_DONE;
              end else begin
                if (!sending) begin
                  data_r <= s_data;
                  dbr_r <= 1'b1;
                end else begin
                  dbr_r <= 1'b1;
                end
                state_r <= S_XACK;
              end
            end
          end else if (!s_ack) begin
            if (last_b) begin
              count_r <= (count_r == 12'h000) ? 12'h000 : count_r - 12'h001;
              status_r <= ST_SUCCESS;
              irq_r <= 1'b1;
              state_r <= S_DONE;
            end else begin
              count_r <= count_r - 12'h001;
              state_r <= S_XREQ;
            end
          end
        end
        // One cycle for the interrupt to show before idle
        S_DONE: begin
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
      // Disconnect outside a transfer drops the connection, no interrupt
      if (do_disc && !in_xfer && conn_r != CONN_NONE) begin
        conn_r <= CONN_NONE;
        state_r <= S_IDLE;
      end
    end
  end

  // Pin drive: ids stay on the data lines only while selecting
  wire drive_ids = (state_r == S_SELECT) | (state_r == S_WAIT);
  // Selection id bits: own and target, one-hot on the data lines
  wire [7:0] id_bits = (8'h01 << own_id_r) | (8'h01 << tgt_id_r);
  always_comb begin
    bus_o = '0;
    bus_o.sel = (state_r == S_SELECT) | (state_r == S_WAIT) | (state_r == S_ABSEQ);
    bus_o.atn = bus_o.sel & (op_r == OP_SEL_ATN);
    // BSY held through the select cycle, so SEL and ids are up before it drops
    bus_o.bsy = arb_won | (state_r == S_SELECT) | (conn_r == CONN_TARG);
    // Phase lines follow opcode bits: io from bit 2, cd from ~bit 0, msg from bit 1
    bus_o.io  = (bus_o.sel & (op_r == OP_RESELECT)) | (in_xfer & op_r[2]);
    bus_o.cd  = in_xfer & ~op_r[0];
    bus_o.msg = in_xfer & op_r[1];
    bus_o.req = (state_r == S_XREQ) & ~dbr_r & ~tx_perr;
    // Data lines show ids while selecting, else the data register
    bus_o.data = drive_ids ? id_bits : data_r;
    bus_o.dbp = ~(^bus_o.data);
  end
  assign bus_data_oe_o = drive_ids | (in_xfer & sending);
  // Only data phases run synchronously, and only with a nonzero offset
  assign sync_mode_o = in_xfer & ~op_r[1] & op_r[0] & (sync_r[7:4] != 4'h0);
  assign irq_o = irq_r;

endmodule : sss_sequencer

// file: sss_far_end.sv
// Far-side model: a bus initiator that answers selection with BSY and REQ with ACK.
// Assumes the sequencer's pin struct and data enable on the same core clock.
`timescale 1ns/1ps
module sss_far_end
  import sss_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  // Bench controls
  input  wire logic       answer_i,
  input  wire logic       perr_i,
  input  wire logic [7:0] tx_i,
  // Sequencer pins
  input  wire sss_bus_t   bus_i,
  input  wire logic       oe_i,
  output logic            bsy_o,
  output logic            ack_o,
  output logic [7:0]      data_o,
  output logic            dbp_o,
  output logic [7:0]      rx_o,
  output logic [7:0]      n_o
);
  logic [7:0] last_r;
  wire        drv = !bus_i.io && (bus_i.req || ack_o);
  // Wire level: sequencer, then this model, else a changing pattern, never a stale byte
  assign data_o = oe_i ? bus_i.data : (drv ? tx_i : ~last_r);
  assign dbp_o  = oe_i ? bus_i.dbp : (drv ? (~^tx_i ^ perr_i) : ~(^last_r));
  // Cleared by reset so the idle pattern is never unknown
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) last_r <= 8'h00;
    else last_r <= data_o;
  end
  // BSY answers a selection only while told to, then holds until told to leave
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || !answer_i) bsy_o <= 1'b0;
    else if (bus_i.sel && !bus_i.bsy) bsy_o <= 1'b1;
  end
  // One ACK per REQ; ACK follows REQ down, so a slow REQ drop is never counted twice
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      ack_o <= 1'b0;
      n_o   <= 8'h00;
      rx_o  <= 8'h00;
    end else if (bus_i.req && !ack_o) begin
      ack_o <= 1'b1;
      n_o   <= n_o + 8'h01;
      if (bus_i.io) rx_o <= bus_i.data;
    end else if (!bus_i.req) ack_o <= 1'b0;
  end
endmodule : sss_far_end

// file: sss_sequencer_checker.sv
// Checker of the sequencer's pin behaviour, bound into every sequencer instance.
// Assumes a command is written whole in one Avalon write to the command offset.
`timescale 1ns/1ps
module sss_sequencer_checker
  import sss_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  // Register bus and target BSY
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic        bus_bsy_i,
  // Watched outputs
  input wire sss_bus_t    bus_o,
  input wire logic        bus_data_oe_o,
  input wire logic        sync_mode_o
);
  logic [7:0] xfer_r;
  logic [7:0] sel_r;
  wire        cmd_wr = avs_write_i && avs_address_i == REG_CMD_OFS;
  wire  [7:0] op     = avs_writedata_i[7:0];
  // Last opcodes; refused ones never reach the pins, so the pins still judge them
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      xfer_r <= 8'h00;
      sel_r  <= 8'h00;
    end else if (cmd_wr && op >= OP_RECV_BASE && op <= OP_XFER_LAST) xfer_r <= op;
    else if (cmd_wr && op >= OP_RESELECT && op <= OP_SEL_NOATN) sel_r <= op;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_sel_up;
    $rose(bus_o.sel);
  endsequence
  sequence s_xfer;
    bus_o.req && !bus_o.sel;
  endsequence
  sequence s_answer;
    $rose(bus_bsy_i) && bus_o.sel && !bus_o.bsy;
  endsequence
  a_sel_after_arb: assert property (s_sel_up |-> $past(bus_o.bsy) && bus_o.bsy)
    else $error("SEL rose without BSY held");
  a_sel_ids: assert property (s_sel_up |-> bus_data_oe_o)
    else $error("SEL rose without ids on the data lines");
  a_atn_sel: assert property (s_sel_up ##0 sel_r == OP_SEL_ATN |-> bus_o.atn)
    else $error("ATN missing at selection");
  a_no_atn: assert property (bus_o.sel && sel_r != OP_SEL_ATN |-> !bus_o.atn)
    else $error("ATN driven without attention select");
  a_resel_io: assert property (bus_o.sel && sel_r == OP_RESELECT |-> bus_o.io)
    else $error("IO low during reselection");
  a_phase_code: assert property (s_xfer |->
    {bus_o.msg, bus_o.cd, bus_o.io} == {xfer_r[1], !xfer_r[0], xfer_r[2]})
    else $error("Phase lines do not match the opcode");
  a_recv_float: assert property (s_xfer ##0 !bus_o.io |-> !bus_data_oe_o)
    else $error("Data driven during receive");
  a_send_drive: assert property (s_xfer ##0 bus_o.io |-> bus_data_oe_o)
    else $error("Data not driven during send");
  a_sync_data: assert property (sync_mode_o |-> !bus_o.cd && !bus_o.msg)
    else $error("Synchronous mode outside a data phase");
  a_sel_drops: assert property (s_answer |-> ##[1:8] !bus_o.sel)
    else $error("SEL kept after target BSY");
endmodule : sss_sequencer_checker

bind sss_sequencer sss_sequencer_checker u_chk (
  .core_clk_i, .rst_b_i, .avs_address_i, .avs_write_i, .avs_writedata_i,
  .bus_bsy_i, .bus_o, .bus_data_oe_o, .sync_mode_o
);

// file: sss_sequencer_tb.sv
// Bench: Avalon tasks, far-end initiator model, random bytes from a fixed LFSR seed.
// Assumes the checker is bound into the design and the far end answers every REQ.
`timescale 1ns/1ps
module sss_sequencer_tb;
  import sss_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [5:0]  avs_address_i = 6'h00;
  logic        avs_read_i = 1'b0, avs_write_i = 1'b0, host_parity_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, v, seed = 32'h0001857B;
  logic        avs_waitrequest_o, bus_data_oe_o, sync_mode_o, irq_o, bsy, ack, dbp;
  logic        bus_sel_i = 1'b0, bus_atn_i = 1'b0, bus_lost_i = 1'b0, single_byte_mode_bit;
  logic        answer = 1'b0, perr = 1'b0;
  logic [7:0]  tx = 8'h00, data, rx, nx, b, op;
  sss_bus_t    bus_o;
  int          mismatches = 0, n_checks = 0, k, j, m, tot = 0;
  // Clock at 50 MHz
  always #10 core_clk_i = ~core_clk_i;
  sss_sequencer #(.ABORT_CYCLES(20), .TMO_UNIT(4)) DUT (
    .core_clk_i, .clk_en_i(1'b1), .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .host_parity_i,
    .bus_bsy_i(bsy), .bus_sel_i, .bus_atn_i, .bus_ack_i(ack), .bus_lost_i,
    .bus_data_i(data), .bus_dbp_i(dbp), .bus_o, .bus_data_oe_o, .sync_mode_o, .irq_o);
  sss_far_end u_far (.core_clk_i, .rst_b_i, .answer_i(answer), .perr_i(perr), .tx_i(tx),
    .bus_i(bus_o), .oe_i(bus_data_oe_o), .bsy_o(bsy), .ack_o(ack), .data_o(data),
    .dbp_o(dbp), .rx_o(rx), .n_o(nx));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Bytes moved: one when the counter is off or loaded with zero, else the loaded count
  function automatic int nbytes(input logic [1:0] n, input logic s);
    return (s || n == 2'b00) ? 1 : int'(n);
  endfunction : nbytes
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One transfer, held until waitrequest is low at a rising edge; reads land in v
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk_i);
      if (avs_waitrequest_o === 1'b0) begin
        v = avs_readdata_o;
        break;
      end
    end
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (i == 50) begin
      mismatches++;
      results();
    end
  endtask : bus
  task automatic cmd(input logic [7:0] c, input logic s = 1'b0);
    bus(1'b1, REG_CMD_OFS, {23'h0, s, c});
  endtask : cmd
  // Bounded wait for the interrupt, then the status code
  task automatic wirq(input logic [7:0] st);
    int i;
    for (i = 0; i < 3000 && irq_o !== 1'b1; i++) @(negedge core_clk_i);
    if (irq_o !== 1'b1) begin
      mismatches++;
      results();
    end
    bus(1'b0, REG_STAT_OFS, 32'h0);
    chk(v[7:0], st);
  endtask : wirq
  // Poll the ready flag as software without DMA would
  task automatic wdbr(input logic e);
    for (int i = 0; i < 40; i++) begin
      bus(1'b0, REG_AUX_OFS, 32'h0);
      if (v[0] === e) break;
    end
    chk(v[0], e);
  endtask : wdbr
  // Main sequence: selections first, then target transfers over every opcode
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    bus(1'b0, REG_AUX_OFS, 32'h0);
    chk(v, 32'h0);
    chk(bus_o.dbp, 1'b1);
    bus(1'b1, REG_IDS_OFS, 32'h00000207); // ids
    answer <= 1'b1;
    cmd(OP_SEL_ATN);
    wirq(ST_SUCCESS); // status
    cmd(OP_SEL_NOATN);
    repeat (300) @(negedge core_clk_i);
    chk(irq_o, 1'b0); // refused
    cmd(OP_DISCONNECT);
    answer <= 1'b0;
    bus(1'b1, REG_TMO_OFS, 32'h1);
    cmd(OP_SEL_NOATN);
    wirq(ST_TERMINAT); // status
    bus(1'b1, REG_TMO_OFS, 32'h0);
    bus_lost_i <= 1'b1;
    cmd(OP_SEL_ATN);
    repeat (200) @(negedge core_clk_i);
    chk(irq_o, 1'b0); // no win
    cmd(OP_ABORT);
    bus_lost_i <= 1'b0;
    wirq(ST_PAUSED); // status
    cmd(OP_SEL_ATN);
    bus_sel_i <= 1'b1;
    wirq(ST_SVC_REQ); // status
    bus_sel_i <= 1'b0;
    cmd(OP_DISCONNECT);
    answer <= 1'b1;
    cmd(OP_RESELECT);
    wirq(ST_SUCCESS); // status
    $display("selection tests done");
    for (k = 0; k < 10; k++) begin
      seed = lfsr(seed);
      op = k < 8 ? OP_RECV_BASE + 8'(k) : OP_SEND_BASE + 8'(k - 7);
      single_byte_mode_bit = k == 2;
      m = nbytes(seed[9:8], single_byte_mode_bit);
      tx <= seed[7:0];
      if (k == 8) bus(1'b1, REG_SYNC_OFS, 32'h12);
      bus(1'b0, REG_AUX_OFS, 32'h0);
      chk(v[3:2], CONN_TARG); // state
      bus(1'b1, REG_COUNT_OFS, {30'h0, seed[9:8]});
      cmd(op, single_byte_mode_bit);
      if (k >= 8) begin
        @(negedge core_clk_i);
        chk(sync_mode_o, k == 8); // mode
      end
      for (j = 0; j < m; j++) begin
        b = seed[7:0] + 8'(j * 53);
        wdbr(1'b1); // flag
        if (!op[2]) begin
          tx <= b + 8'd53;
          bus(1'b0, REG_DATA_OFS, 32'h0);
          chk(v[7:0], b); // byte
        end else begin
          host_parity_i <= ~^b;
          bus(1'b1, REG_DATA_OFS, {24'h0, b});
        end
      end
      wirq(ST_SUCCESS); // done
      tot += m;
      chk(nx, 8'(tot)); // count
      if (op[2]) chk(rx, b); // byte
      else wdbr(1'b0); // flag
      $display("transfer %h done", op);
    end
    bus(1'b1, REG_SYNC_OFS, 32'h0);
    bus(1'b1, REG_CTRL_OFS, 32'h10);
    perr <= 1'b1;
    bus(1'b1, REG_COUNT_OFS, 32'h3);
    cmd(OP_RECV_BASE + 8'h01);
    wirq(ST_TERMINAT); // parity
    perr <= 1'b0;
    bus(1'b0, REG_COUNT_OFS, 32'h0);
    chk(v[11:0], 12'h3); // left
    bus(1'b1, REG_CTRL_OFS, 32'h20);
    cmd(OP_SEND_BASE + 8'h01);
    host_parity_i <= 1'b0;
    bus(1'b1, REG_DATA_OFS, 32'h0);
    wirq(ST_TERMINAT); // parity
    $display("parity tests done");
    bus(1'b1, REG_CTRL_OFS, 32'h40);
    bus_atn_i <= 1'b1;
    cmd(OP_RECV_BASE);
    wirq(ST_PAUSED); // halt
    bus_atn_i <= 1'b0;
    bus(1'b0, REG_AUX_OFS, 32'h0);
    chk(v[3:2], CONN_TARG); // state
    cmd(OP_DISCONNECT);
    bus(1'b0, REG_AUX_OFS, 32'h0);
    chk(v[3:2], CONN_NONE); // state
    $display("halt and disconnect tests done");
    results();
  end
endmodule : sss_sequencer_tb
